// >>> pmcs_defs.vh
// pmcs_defs.vh: register map, field positions, reset values and timing counts
// for the power-mode clock selector; included by the top module and the testbench
`ifndef PMCS_DEFS_VH
`define PMCS_DEFS_VH

// byte addresses on the ahb-lite register window
`define PMCS_ADDR_OSC_CTRL   8'h00
`define PMCS_ADDR_TMR1_CTRL  8'h04
`define PMCS_ADDR_FEAT_CTRL  8'h08
`define PMCS_ADDR_CMD        8'h0c
`define PMCS_ADDR_STATUS     8'h10

// oscillator control register fields
`define PMCS_OSC_IDLE_BIT    7
`define PMCS_OSC_PRIACT_BIT  3
`define PMCS_OSC_SEL_HI      1
`define PMCS_OSC_SEL_LO      0
`define PMCS_OSC_RESET       8'h02

// timer one control register fields
`define PMCS_T1_RUN_BIT      6
`define PMCS_T1_OSCEN_BIT    3

// feature control register fields
`define PMCS_FEAT_TWOSPD_BIT 0
`define PMCS_FEAT_FSCM_BIT   1
`define PMCS_FEAT_WDT_BIT    2

// command register fields
`define PMCS_CMD_SLEEP_BIT   0

// source select encodings
`define PMCS_SEL_PRI         2'h2
`define PMCS_SEL_SEC         2'h1
`define PMCS_SEL_INT         2'h3
`define PMCS_SEL_INT_ALT     2'h0

// handover: two old-clock cycles plus up to four new-clock cycles
`define PMCS_SWITCH_OLD_CYC  3'h2
`define PMCS_SWITCH_NEW_CYC  3'h4

// core-ready delay, in nanoseconds, and its count at 10 mhz
`define PMCS_CLK_PERIOD_NS   100
`define PMCS_CORE_READY_NS   10000
`define PMCS_CORE_READY_CYC  ((`PMCS_CORE_READY_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS)

`endif

// >>> pmcs_sync.v
// pmcs_sync.v: two-flop synchroniser for oscillator ready and wake pins
// assumes the inputs are asynchronous levels from outside clk_i's domain
`timescale 1ns/1ps
module pmcs_sync #(
  parameter W = 4
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// >>> pmcs_top.v
// pmcs_top.v: power-mode clock selector with an ahb-lite register slave
// assumes one 10 mhz clock; oscillator ready and wake inputs are async pins
`timescale 1ns/1ps
`include "pmcs_defs.vh"
module pmcs_top #(
  parameter CORE_READY_CYC = `PMCS_CORE_READY_CYC
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        hsel_i,
  input  wire [7:0]  haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  input  wire        pri_ready_i,
  input  wire        sec_ready_i,
  input  wire        int_ready_i,
  input  wire        wake_irq_i,
  input  wire        wdt_timeout_i,
  output reg  [1:0]  clk_src_o,
  output reg         cpu_clk_en_o,
  output reg         per_clk_en_o,
  output reg         pri_osc_en_o,
  output reg         sec_osc_en_o,
  output reg         int_osc_en_o,
  output reg         lf_rc_en_o,
  output reg         cpu_run_o
);
  // modes
  localparam [2:0] ST_RUN    = 3'h0;
  localparam [2:0] ST_SWITCH = 3'h1;
  localparam [2:0] ST_IDLE   = 3'h2;
  localparam [2:0] ST_SLEEP  = 3'h3;
  localparam [2:0] ST_WAKE   = 3'h4;
  localparam [2:0] ST_DELAY  = 3'h5;

  // clock source codes on clk_src_o
  localparam [1:0] SRC_NONE = 2'h0;
  localparam [1:0] SRC_SEC  = 2'h1;
  localparam [1:0] SRC_PRI  = 2'h2;
  localparam [1:0] SRC_INT  = 2'h3;

  function [1:0] sel_to_src;
    input [1:0] sel;
    begin
      if (sel == `PMCS_SEL_PRI)
        sel_to_src = SRC_PRI;
      else if (sel == `PMCS_SEL_SEC)
        sel_to_src = SRC_SEC;
      else
        sel_to_src = SRC_INT;
    end
  endfunction

  function src_ready;
    input [1:0] src;
    input       p;
    input       s;
    input       i;
    begin
      case (src)
        SRC_PRI: src_ready = p;
        SRC_SEC: src_ready = s;
        SRC_INT: src_ready = i;
        default: src_ready = 1'b0;
      endcase
    end
  endfunction

  wire [3:0] pins_s;
  pmcs_sync #(.W(4)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({wdt_timeout_i, wake_irq_i, sec_ready_i, pri_ready_i}),
    .q_o     (pins_s)
  );
  wire pri_rdy = pins_s[0];
  wire sec_rdy = pins_s[1];
  wire wake_ev = pins_s[2] | pins_s[3];
  wire wdt_ev  = pins_s[3];
  reg  int_meta_q;
  reg  int_rdy_q;

  // software-visible state
  reg        idle_en_q;
  reg  [1:0] sel_q;
  reg        sec_osc_en_q;
  reg        two_speed_q;
  reg        fscm_en_q;
  reg        wdt_en_q;
  reg        pri_flag_q;
  reg        sec_flag_q;

  // controller state
  reg  [2:0]  state_q;
  reg  [1:0]  cur_src_q;
  reg  [1:0]  tgt_src_q;
  reg         slp_idle_q;
  reg         wake_on_int_q;
  reg  [2:0]  sw_cnt_q;
  reg  [15:0] dly_cnt_q;

  // ahb-lite address phase capture
  reg        wr_pend_q;
  reg  [7:0] addr_q;
  wire       take = hsel_i & htrans_i[1] & hready_i;

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  wire wr_osc = wr_pend_q & (addr_q == `PMCS_ADDR_OSC_CTRL);
  wire wr_t1  = wr_pend_q & (addr_q == `PMCS_ADDR_TMR1_CTRL);
  wire wr_ft  = wr_pend_q & (addr_q == `PMCS_ADDR_FEAT_CTRL);
  wire slp_cmd = wr_pend_q & (addr_q == `PMCS_ADDR_CMD) &
                 hwdata_i[`PMCS_CMD_SLEEP_BIT];

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_meta_q <= 1'b0;
      int_rdy_q  <= 1'b0;
    end else begin
      int_meta_q <= int_ready_i;
      int_rdy_q  <= int_meta_q;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite_i;
      if (take)
        addr_q <= haddr_i;
    end
  end

  // register writes; only software changes idle enable and select
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      idle_en_q    <= 1'b0;
      sel_q        <= `PMCS_SEL_PRI;
      sec_osc_en_q <= 1'b0;
      two_speed_q  <= 1'b0;
      fscm_en_q    <= 1'b0;
      wdt_en_q     <= 1'b0;
    end else begin
      if (wr_osc) begin
        idle_en_q <= hwdata_i[`PMCS_OSC_IDLE_BIT];
        sel_q     <= hwdata_i[`PMCS_OSC_SEL_HI:`PMCS_OSC_SEL_LO];
      end
      if (wr_t1)
        sec_osc_en_q <= hwdata_i[`PMCS_T1_OSCEN_BIT];
      if (wr_ft) begin
        two_speed_q <= hwdata_i[`PMCS_FEAT_TWOSPD_BIT];
        fscm_en_q   <= hwdata_i[`PMCS_FEAT_FSCM_BIT];
        wdt_en_q    <= hwdata_i[`PMCS_FEAT_WDT_BIT];
      end
    end
  end

  wire [1:0] want_src = sel_to_src(sel_q);
  wire       want_ok  = (want_src != SRC_SEC) | sec_osc_en_q;
  wire       rdy_tgt  = src_ready(tgt_src_q, pri_rdy, sec_rdy, int_rdy_q);

  // mode controller
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q       <= ST_RUN;
      cur_src_q     <= SRC_PRI;
      tgt_src_q     <= SRC_PRI;
      pri_flag_q    <= 1'b1;
      sec_flag_q    <= 1'b0;
      slp_idle_q    <= 1'b0;
      wake_on_int_q <= 1'b0;
      sw_cnt_q      <= 3'h0;
      dly_cnt_q     <= 16'h0000;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (slp_cmd && !(idle_en_q && !want_ok)) begin
            slp_idle_q <= idle_en_q;
            tgt_src_q  <= want_src;
            if (idle_en_q && want_src == cur_src_q) begin
              state_q <= ST_IDLE;
            end else if (idle_en_q) begin
              sw_cnt_q <= 3'h0;
              state_q  <= ST_SWITCH;
            end else begin
              cur_src_q  <= SRC_NONE;
              pri_flag_q <= 1'b0;
              sec_flag_q <= 1'b0;
              state_q    <= ST_SLEEP;
            end
          end else if (want_src != cur_src_q && want_ok) begin
            slp_idle_q <= 1'b0;
            tgt_src_q  <= want_src;
            sw_cnt_q   <= 3'h0;
            state_q    <= ST_SWITCH;
          end
        end
        ST_SWITCH: begin
          // a sleep with idle set before the last cycle of a run switch ends it in idle
          if (slp_cmd && idle_en_q)
            slp_idle_q <= 1'b1;
          // old source keeps clocking until the new one is ready
          if (!rdy_tgt)
            sw_cnt_q <= 3'h0;
          else if (sw_cnt_q != `PMCS_SWITCH_OLD_CYC + `PMCS_SWITCH_NEW_CYC)
            sw_cnt_q <= sw_cnt_q + 3'h1;
          else begin
            cur_src_q  <= tgt_src_q;
            pri_flag_q <= (tgt_src_q == SRC_PRI);
            sec_flag_q <= (tgt_src_q == SRC_SEC);
            state_q    <= slp_idle_q ? ST_IDLE : ST_RUN;
          end
        end
        ST_IDLE: begin
          if (wake_ev) begin
            dly_cnt_q <= 16'h0000;
            state_q   <= ST_DELAY;
          end
        end
        ST_SLEEP: begin
          if (wake_ev) begin
            tgt_src_q     <= want_src;
            wake_on_int_q <= two_speed_q | fscm_en_q;
            state_q       <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_on_int_q && cur_src_q == SRC_NONE && int_rdy_q)
            cur_src_q <= SRC_INT;
          if (rdy_tgt) begin
            cur_src_q  <= tgt_src_q;
            pri_flag_q <= (tgt_src_q == SRC_PRI);
            sec_flag_q <= (tgt_src_q == SRC_SEC);
            dly_cnt_q  <= 16'h0000;
            state_q    <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (dly_cnt_q == CORE_READY_CYC[15:0] - 16'h0001)
            state_q <= ST_RUN;
          else
            dly_cnt_q <= dly_cnt_q + 16'h0001;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // clock gating and oscillator enables
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_src_o    <= SRC_PRI;
      cpu_clk_en_o <= 1'b1;
      per_clk_en_o <= 1'b1;
      pri_osc_en_o <= 1'b1;
      sec_osc_en_o <= 1'b0;
      int_osc_en_o <= 1'b0;
      lf_rc_en_o   <= 1'b0;
      cpu_run_o    <= 1'b1;
    end else begin
      clk_src_o    <= cur_src_q;
      per_clk_en_o <= (cur_src_q != SRC_NONE);
      cpu_clk_en_o <= (cur_src_q != SRC_NONE) &&
                      (state_q != ST_IDLE);
      cpu_run_o    <= (state_q == ST_RUN) ||
                      (state_q == ST_SWITCH && !slp_idle_q);
      // primary stays up in primary idle and while it is being started
      pri_osc_en_o <= (cur_src_q == SRC_PRI) ||
                      (tgt_src_q == SRC_PRI &&
                       (state_q == ST_SWITCH || state_q == ST_WAKE));
      sec_osc_en_o <= sec_osc_en_q;
      int_osc_en_o <= (cur_src_q == SRC_INT) || (tgt_src_q == SRC_INT &&
                      state_q != ST_SLEEP) ||
                      (state_q == ST_WAKE && wake_on_int_q);
      lf_rc_en_o   <= wdt_en_q | fscm_en_q;
    end
  end

  // read data
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= 32'h00000000;
      case (haddr_i)
        `PMCS_ADDR_OSC_CTRL: begin
          hrdata_o[`PMCS_OSC_IDLE_BIT]   <= idle_en_q;
          hrdata_o[`PMCS_OSC_PRIACT_BIT] <= pri_flag_q;
          hrdata_o[`PMCS_OSC_SEL_HI:`PMCS_OSC_SEL_LO] <= sel_q;
        end
        `PMCS_ADDR_TMR1_CTRL: begin
          hrdata_o[`PMCS_T1_RUN_BIT]   <= sec_flag_q;
          hrdata_o[`PMCS_T1_OSCEN_BIT] <= sec_osc_en_q;
        end
        `PMCS_ADDR_FEAT_CTRL: begin
          hrdata_o[`PMCS_FEAT_TWOSPD_BIT] <= two_speed_q;
          hrdata_o[`PMCS_FEAT_FSCM_BIT]   <= fscm_en_q;
          hrdata_o[`PMCS_FEAT_WDT_BIT]    <= wdt_en_q;
        end
        `PMCS_ADDR_STATUS: begin
          hrdata_o[2:0] <= state_q;
          hrdata_o[5:4] <= cur_src_q;
        end
        default: hrdata_o <= 32'h00000000;
      endcase
    end
  end
endmodule

// >>> pmcs_props_properties.sv
// pmcs_props_properties.sv: port checker for the power-mode clock selector
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module pmcs_props #(
  parameter CORE_READY_CYC = 4
) (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       hreadyout_o,
  input wire       hresp_o,
  input wire       sec_ready_i,
  input wire [1:0] clk_src_o,
  input wire       cpu_clk_en_o,
  input wire       per_clk_en_o,
  input wire       pri_osc_en_o,
  input wire       sec_osc_en_o,
  input wire       int_osc_en_o,
  input wire       cpu_run_o
);
  reg [15:0] dly_q;
  // counts consecutive cycles with the cpu held off
  always @(posedge clk_i) begin
    if (!rst_n_i || cpu_run_o)
      dly_q <= 16'h0000;
    else if (dly_q != 16'hffff)
      dly_q <= dly_q + 16'h0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_resume;
    !cpu_run_o ##1 cpu_run_o;
  endsequence
  a_run_clk_both: assert property (cpu_run_o |-> cpu_clk_en_o && per_clk_en_o)
    else $error("cpu runs without both clocks");
  a_cpu_gate_only: assert property (!cpu_clk_en_o |-> !cpu_run_o)
    else $error("cpu runs with its clock gated");
  a_sleep_all_off: assert property (!per_clk_en_o |-> !cpu_clk_en_o)
    else $error("cpu clock on while peripherals off");
  a_pri_src_osc: assert property (clk_src_o == 2'h2 |-> pri_osc_en_o)
    else $error("primary source without its oscillator");
  a_sec_src_osc: assert property (clk_src_o == 2'h1 |-> sec_osc_en_o)
    else $error("secondary source without its oscillator");
  a_int_src_osc: assert property (clk_src_o == 2'h3 |-> int_osc_en_o)
    else $error("internal source without its oscillator");
  a_sec_wait_ready: assert property (per_clk_en_o && clk_src_o == 2'h1
    |-> $past(sec_ready_i, 2))
    else $error("clocked from secondary before it started");
  a_wake_delay: assert property (s_resume |-> dly_q >= CORE_READY_CYC)
    else $error("cpu resumed before the core-ready delay");
  a_none_gated: assert property (clk_src_o == 2'h0 |-> !per_clk_en_o)
    else $error("clocks on with no source");
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
endmodule

bind pmcs_top pmcs_props #(.CORE_READY_CYC(CORE_READY_CYC)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .sec_ready_i(sec_ready_i), .clk_src_o(clk_src_o),
  .cpu_clk_en_o(cpu_clk_en_o), .per_clk_en_o(per_clk_en_o),
  .pri_osc_en_o(pri_osc_en_o), .sec_osc_en_o(sec_osc_en_o),
  .int_osc_en_o(int_osc_en_o), .cpu_run_o(cpu_run_o));

// >>> pmcs_osc_model.sv
// pmcs_osc_model.sv: oscillator that reports ready some cycles after enable
// assumes the enable comes from the selector; ready drops at once when off
`timescale 1ns/1ps
module pmcs_osc_model #(
  parameter DLY = 8
) (
  input  wire clk_i,
  input  wire en_i,
  output reg  ready_o
);
  reg [7:0] cnt_q = 8'h00;
  initial ready_o = 1'b0;
  // start-up time before the oscillator is usable
  always @(posedge clk_i) begin
    if (en_i !== 1'b1) begin
      cnt_q   <= 8'h00;
      ready_o <= 1'b0;
    end else if (cnt_q != DLY) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      ready_o <= 1'b1;
    end
  end
endmodule

// >>> tb_pmcs_top.sv
// tb_pmcs_top.sv: register-level test of the power-mode clock selector
// assumes oscillator models on the ready pins and a zero-wait bus slave
`timescale 1ns/1ps
`include "pmcs_defs.vh"
module tb_pmcs_top;
  localparam [7:0] OSC = `PMCS_ADDR_OSC_CTRL;
  localparam [7:0] TM1 = `PMCS_ADDR_TMR1_CTRL;
  localparam [7:0] FEA = `PMCS_ADDR_FEAT_CTRL;
  localparam [7:0] CMD = `PMCS_ADDR_CMD;
  reg         clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [7:0]  haddr = 8'h00;
  reg         hsel = 1'b0;
  reg  [2:0]  hsize = 3'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         wake = 1'b0;
  reg         wdt = 1'b0;
  reg  [31:0] rd;
  wire [31:0] hrdata;
  wire        hrdy, hresp, p_rdy, s_rdy, i_rdy;
  wire [1:0]  src;
  wire        c_en, p_en, po, so, io, lf, run;
  wire [8:0]  pins = {src, c_en, p_en, po, so, io, lf, run};
  integer     error_cnt = 0;
  integer     n_checks = 0;
  integer     t = 0;
  always #50 clk_i = ~clk_i;
  pmcs_top #(.CORE_READY_CYC(4)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .pri_ready_i(p_rdy),
    .sec_ready_i(s_rdy), .int_ready_i(i_rdy), .wake_irq_i(wake),
    .wdt_timeout_i(wdt), .clk_src_o(src), .cpu_clk_en_o(c_en),
    .per_clk_en_o(p_en), .pri_osc_en_o(po), .sec_osc_en_o(so),
    .int_osc_en_o(io), .lf_rc_en_o(lf), .cpu_run_o(run));
  pmcs_osc_model #(.DLY(10)) u_pri (.clk_i(clk_i), .en_i(po), .ready_o(p_rdy));
  pmcs_osc_model #(.DLY(40)) u_sec (.clk_i(clk_i), .en_i(so), .ready_o(s_rdy));
  pmcs_osc_model #(.DLY(3)) u_int (.clk_i(clk_i), .en_i(io), .ready_o(i_rdy));
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chp(input [8:0] m, input [8:0] e);
    chk({23'h0, pins & m}, {23'h0, e});
  endtask
  task wt(input [8:0] m, input [8:0] e);
    integer n;
    begin
      n = 0;
      while ((pins & m) !== e) begin
        n = n + 1;
        if (n > 3000) begin
          error_cnt = error_cnt + 1;
          stop_test;
        end
        @(posedge clk_i);
        #1;
      end
    end
  endtask
  task hwait;
    integer n;
    begin
      n = 0;
      @(posedge clk_i);
      while (hrdy !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          error_cnt = error_cnt + 1;
          stop_test;
        end
        @(posedge clk_i);
      end
    end
  endtask
  task ahb(input wr, input [7:0] a, input [31:0] d);
    begin
      hsel   <= 1'b1;
      hsize  <= 3'h2;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      hwait;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hwait;
      rd = hrdata;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  task endt;
    begin
      t = t + 1;
      $display("test %0d done", t);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chp(9'h1f1, 9'h171);
    ahb(0, OSC, 0); chk(rd, 32'h0a);
    chk({31'h0, hresp}, 32'h0);
    ahb(0, 8'h20, 0); chk(rd, 32'h0); endt;
    ahb(1, OSC, 32'h01); tick(30); chp(9'h180, 9'h100);
    ahb(0, OSC, 0); chk(rd, 32'h09); endt;
    ahb(1, TM1, 32'h08); wt(9'h180, 9'h080);
    chp(9'h1f9, 9'h0e9);
    ahb(0, OSC, 0); chk(rd, 32'h01);
    ahb(0, TM1, 0); chk(rd, 32'h48); endt;
    ahb(1, OSC, 32'h02); chp(9'h180, 9'h080);
    wt(9'h180, 9'h100); chp(9'h008, 9'h008);
    ahb(0, TM1, 0); chk(rd, 32'h08);
    ahb(0, OSC, 0); chk(rd, 32'h0a); endt;
    ahb(1, OSC, 32'h03); wt(9'h180, 9'h180); chp(9'h010, 9'h000);
    ahb(0, OSC, 0); chk(rd, 32'h03);
    ahb(1, OSC, 32'h02); chp(9'h180, 9'h180);
    wt(9'h180, 9'h100); ahb(0, OSC, 0); chk(rd, 32'h0a); endt;
    ahb(1, OSC, 32'h82); ahb(1, CMD, 32'h01);
    wt(9'h061, 9'h020); chp(9'h190, 9'h110);
    ahb(0, OSC, 0); chk(rd, 32'h8a);
    wake <= 1'b1; wt(9'h001, 9'h001); wake <= 1'b0;
    chp(9'h1f1, 9'h171); ahb(0, OSC, 0); chk(rd, 32'h8a); endt;
    ahb(1, OSC, 32'h81); ahb(1, CMD, 32'h01);
    wt(9'h061, 9'h020); chp(9'h198, 9'h088);
    ahb(0, TM1, 0); chk(rd, 32'h48);
    wake <= 1'b1; wt(9'h001, 9'h001); wake <= 1'b0;
    chp(9'h180, 9'h080); endt;
    ahb(1, OSC, 32'h80); ahb(1, CMD, 32'h01);
    wt(9'h061, 9'h020); chp(9'h194, 9'h184);
    ahb(0, OSC, 0); chk(rd, 32'h80);
    wake <= 1'b1; wt(9'h001, 9'h001); wake <= 1'b0;
    chp(9'h180, 9'h180);
    ahb(1, OSC, 32'h02); wt(9'h180, 9'h100); endt;
    ahb(1, OSC, 32'h02); ahb(1, FEA, 32'h04); ahb(1, CMD, 32'h01);
    wt(9'h020, 9'h000); chp(9'h05f, 9'h00a);
    ahb(0, OSC, 0); chk(rd, 32'h02);
    ahb(0, TM1, 0); chk(rd, 32'h08);
    wdt <= 1'b1; wt(9'h001, 9'h001); wdt <= 1'b0;
    chp(9'h1f3, 9'h173);
    ahb(0, OSC, 0); chk(rd, 32'h0a); endt;
    ahb(1, TM1, 32'h00); ahb(1, OSC, 32'h81); ahb(1, CMD, 32'h01);
    tick(30); chp(9'h1e1, 9'h161); endt;
    ahb(1, OSC, 32'h02); ahb(1, FEA, 32'h01); ahb(1, CMD, 32'h01);
    wt(9'h020, 9'h000); wake <= 1'b1; wt(9'h180, 9'h180);
    wt(9'h001, 9'h001); wake <= 1'b0; chp(9'h180, 9'h100);
    ahb(0, OSC, 0); chk(rd, 32'h0a); endt;
    rst_n_i <= 1'b0; tick(2); rst_n_i <= 1'b1; tick(1);
    chp(9'h1ff, 9'h171);
    ahb(0, FEA, 0); chk(rd, 32'h0);
    ahb(0, OSC, 0); chk(rd, 32'h0a); endt;
    stop_test;
  end
endmodule
